// *** logic/port_pin_override_logic.sv ***
// Port pin override logic with Avalon-MM register slave.
//
// What this block does
// R01 - No override: pull-up when dir,drive,disable = 010
// R02 - Override enable: pull-up follows override value
// R03 - Direction override selects output buffer enable
// R04 - Output level from value override or drive
// R05 - Input enable override, else sleep state
// R06 - Alternate input taken before the synchroniser
// R07 - Clamp inputs in deep sleep modes
// R08 - Enabled interrupt pins bypass the clamp
// R09 - Clamped high interrupt pin flags on wake
// R10 - Global disable bit kills pull-ups not under override
// R11 - Pull-ups off while reset active
// R12 - Async timer select hands pin seven over
// R13 - Takeover needs RC clock and async timer
// R14 - Crystal mode takes pin seven as clock
// R15 - Clock pin reads zero in direction, drive and sample
// R16 - Software waits one instruction before readback
// R17 - Pins without alternate function: overrides zero
// R18 - Direction one drives drive value out
// R19 - Sample bit passes through synchroniser
`include "port_pin_consts.svh"
module port_pin_override_logic
    import port_pin_pkg::*;
#(
    parameter int PINS = 8,
    parameter logic [PINS-1:0] ALT_PRESENT = 8'hff
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Avalon-MM slave
    input wire logic [`ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Peripheral overrides
    input wire logic [PINS-1:0] i_pullup_override_enable,
    input wire logic [PINS-1:0] i_pullup_override_value,
    input wire logic [PINS-1:0] i_direction_override_enable,
    input wire logic [PINS-1:0] i_direction_override_value,
    input wire logic [PINS-1:0] i_value_override_enable,
    input wire logic [PINS-1:0] i_value_override_value,
    input wire logic [PINS-1:0] i_input_enable_override_enable,
    input wire logic [PINS-1:0] i_input_enable_override_value,
    input wire logic [2:0] i_sleep_mode,
    // Pads
    input wire logic [PINS-1:0] i_pad_in,
    output logic [PINS-1:0] o_pad_out,
    output logic [PINS-1:0] o_pad_oe,
    output logic [PINS-1:0] o_pad_pullup,
    output logic [PINS-1:0] o_alt_digital_input,
    output logic o_timer_osc_out_enable,
    output logic o_crystal_out_enable
);

    initial
    begin
        if (PINS < `PIN_SEVEN + 5 || PINS > 32)
        begin
            $error("port_pin_override_logic: PINS must be 8..32");
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [PINS-1:0] direction_bit;
    logic [PINS-1:0] drive_value_bit;
    logic [7:0] special_function_io_control;
    logic [7:0] system_ctrl;
    logic [PINS-1:0] int_enable;
    logic [PINS-1:0] int_flag;
    logic [PINS-1:0] next_direction_bit;
    logic [PINS-1:0] next_drive_value_bit;
    logic [7:0] next_special_function_io_control;
    logic [7:0] next_system_ctrl;
    logic [PINS-1:0] next_int_enable;
    logic [PINS-1:0] next_int_flag;
    bus_state_type bus_state;
    bus_state_type next_bus_state;
    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic [PINS-1:0] pin_sample_bit;
    logic was_clamping;

    // ------------------------------------------------------------
    // Combinational pin muxing
    // ------------------------------------------------------------
    logic pullup_global_disable;
    logic pin_seven_taken;
    logic timer_takeover;
    logic crystal_takeover;
    logic deep_sleep;
    logic [PINS-1:0] eff_pu_oe;
    logic [PINS-1:0] eff_pu_ov;
    logic [PINS-1:0] eff_dd_oe;
    logic [PINS-1:0] eff_dd_ov;
    logic [PINS-1:0] eff_pv_oe;
    logic [PINS-1:0] eff_pv_ov;
    logic [PINS-1:0] eff_die_oe;
    logic [PINS-1:0] eff_die_ov;
    logic [PINS-1:0] next_pad_out;
    logic [PINS-1:0] next_pad_oe;
    logic [PINS-1:0] next_pad_pullup;
    logic [PINS-1:0] input_enable;
    logic [PINS-1:0] gated_input;
    logic [PINS-1:0] sync_input;
    logic [PINS-1:0] pad_sync;

    // Word index of a byte address
    function automatic logic [3:0] word_index(input logic [`ADDR_W-1:0] addr);
        word_index = addr[`ADDR_WORD_LSB+3:`ADDR_WORD_LSB];
    endfunction

    // Zero-extend a port vector to bus width
    function automatic logic [31:0] widen(input logic [PINS-1:0] v);
        widen = 32'(v);
    endfunction

    assign pullup_global_disable = special_function_io_control[`SFIO_PULLUP_DISABLE_BIT];
    // Crystal selection means the RC is not the chip clock, so crystal wins pin seven
    assign timer_takeover = system_ctrl[`SYS_ASYNC_TIMER_BIT]
        && system_ctrl[`SYS_INTRC_BIT] && !system_ctrl[`SYS_CRYSTAL_BIT]; // R12 R13
    assign crystal_takeover = system_ctrl[`SYS_CRYSTAL_BIT]; // R14
    assign pin_seven_taken = timer_takeover || crystal_takeover;
    assign deep_sleep = (i_sleep_mode == sleep_power_down_type_v)
        || (i_sleep_mode == sleep_power_save_type_v)
        || (i_sleep_mode == sleep_standby_type_v); // R07

    // Override sources; pins without alternate function see zeros
    always_comb
    begin
        eff_pu_oe = i_pullup_override_enable & ALT_PRESENT; // R17
        eff_pu_ov = i_pullup_override_value & ALT_PRESENT;
        eff_dd_oe = i_direction_override_enable & ALT_PRESENT;
        eff_dd_ov = i_direction_override_value & ALT_PRESENT;
        eff_pv_oe = i_value_override_enable & ALT_PRESENT;
        eff_pv_ov = i_value_override_value & ALT_PRESENT;
        eff_die_oe = i_input_enable_override_enable & ALT_PRESENT;
        eff_die_ov = i_input_enable_override_value & ALT_PRESENT;
        // Clock pin: no pull-up, no driver, input off from port logic
        if (pin_seven_taken)
        begin
            eff_pu_oe[`PIN_SEVEN + 4] = 1'b1; // R12 R14
            eff_pu_ov[`PIN_SEVEN + 4] = 1'b0;
            eff_dd_oe[`PIN_SEVEN + 4] = 1'b1;
            eff_dd_ov[`PIN_SEVEN + 4] = 1'b0;
            eff_pv_oe[`PIN_SEVEN + 4] = 1'b0;
            eff_pv_ov[`PIN_SEVEN + 4] = 1'b0;
            eff_die_oe[`PIN_SEVEN + 4] = 1'b1;
            eff_die_ov[`PIN_SEVEN + 4] = 1'b0;
        end
    end

    // Pull-up, driver enable, output level and input enable per pin
    always_comb
    begin
        for (int i = 0; i < PINS; i++)
        begin
            if (eff_pu_oe[i])
            begin
                next_pad_pullup[i] = eff_pu_ov[i]; // R02
            end
            else
            begin
                next_pad_pullup[i] = ({direction_bit[i], drive_value_bit[i],
                    pullup_global_disable} == 3'b010); // R01 R10
            end
            next_pad_oe[i] = eff_dd_oe[i] ? eff_dd_ov[i] : direction_bit[i]; // R03 R18
            next_pad_out[i] = eff_pv_oe[i] ? eff_pv_ov[i] : drive_value_bit[i]; // R04 R18
            if (eff_die_oe[i])
            begin
                input_enable[i] = eff_die_ov[i]; // R05
            end
            else
            begin
                input_enable[i] = !deep_sleep || int_enable[i]; // R05 R07 R08
            end
        end
    end

    // Clamp to ground at the Schmitt input; alternate users sync themselves
    assign gated_input = i_pad_in & input_enable; // R07
    assign o_alt_digital_input = gated_input; // R06

    // Raw pads ride along so the wake flags never see an unsynchronised level
    pin_input_sync #(
        .WIDTH(2 * PINS)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_pad_in, gated_input}),
        .o_sync({pad_sync, sync_input})
    );

    // Clock pin samples read zero
    always_comb
    begin
        pin_sample_bit = sync_input; // R19
        if (pin_seven_taken)
        begin
            pin_sample_bit[`PIN_SEVEN + 4] = 1'b0; // R15
        end
    end

    // ------------------------------------------------------------
    // Avalon slave and register updates
    // ------------------------------------------------------------
    // Fixed one wait cycle keeps read mux off the critical path
    always_comb
    begin
        next_bus_state = bus_state;
        next_waitrequest = 1'b1;
        next_readdata = o_avs_readdata;
        next_direction_bit = direction_bit;
        next_drive_value_bit = drive_value_bit;
        next_special_function_io_control = special_function_io_control;
        next_system_ctrl = system_ctrl;
        next_int_enable = int_enable;
        next_int_flag = int_flag;
        case (bus_state)
            bus_idle:
            begin
                if (i_avs_read || i_avs_write)
                begin
                    next_bus_state = bus_answer;
                    next_waitrequest = 1'b0;
                    next_readdata = 32'h0;
                    if (i_avs_write)
                    begin
                        case (word_index(i_avs_address))
                            `ADDR_DIRECTION: next_direction_bit = i_avs_writedata[PINS-1:0];
                            `ADDR_DRIVE: next_drive_value_bit = i_avs_writedata[PINS-1:0];
                            `ADDR_SPECIAL_IO:
                                next_special_function_io_control = i_avs_writedata[7:0]; // R10
                            `ADDR_SYSTEM_CTRL: next_system_ctrl = i_avs_writedata[7:0];
                            `ADDR_INT_CTRL: next_int_enable = i_avs_writedata[PINS-1:0];
                            `ADDR_INT_FLAG:
                                next_int_flag = int_flag & ~i_avs_writedata[PINS-1:0];
                            default: next_int_flag = int_flag;
                        endcase
                    end
                    else
                    begin
                        case (word_index(i_avs_address))
                            `ADDR_DIRECTION: next_readdata = widen(pin_seven_taken ?
                                direction_bit & ~(PINS'(1) << (`PIN_SEVEN + 4))
                                : direction_bit); // R15
                            `ADDR_DRIVE: next_readdata = widen(pin_seven_taken ?
                                drive_value_bit & ~(PINS'(1) << (`PIN_SEVEN + 4))
                                : drive_value_bit); // R15
                            `ADDR_SAMPLE: next_readdata = widen(pin_sample_bit); // R19
                            `ADDR_SPECIAL_IO: next_readdata = 32'(special_function_io_control);
                            `ADDR_SYSTEM_CTRL: next_readdata = 32'(system_ctrl);
                            `ADDR_INT_CTRL: next_readdata = widen(int_enable);
                            `ADDR_INT_FLAG: next_readdata = widen(int_flag);
                            default: next_readdata = 32'h0;
                        endcase
                    end
                end
            end
            bus_answer:
            begin
                next_bus_state = bus_idle;
            end
            default:
            begin
                next_bus_state = bus_idle;
            end
        endcase
        // Wake from clamp: high disabled pins see a change; set beats clear
        if (was_clamping && !deep_sleep)
        begin
            next_int_flag = next_int_flag | (pad_sync & ~int_enable); // R09
        end
    end

    // Registers; reset clears the pull-up outputs directly so no pull-ups during reset
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bus_state <= bus_idle;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0;
            direction_bit <= `PORT_RESET;
            drive_value_bit <= `PORT_RESET;
            special_function_io_control <= `SFIO_RESET;
            system_ctrl <= `SYS_RESET;
            int_enable <= `PORT_RESET;
            int_flag <= `PORT_RESET;
            was_clamping <= 1'b0;
            o_pad_out <= '0;
            o_pad_oe <= '0;
            o_pad_pullup <= '0; // R11
            o_timer_osc_out_enable <= 1'b0;
            o_crystal_out_enable <= 1'b0;
        end
        else
        begin
            bus_state <= next_bus_state;
            o_avs_waitrequest <= next_waitrequest;
            o_avs_readdata <= next_readdata;
            direction_bit <= next_direction_bit;
            drive_value_bit <= next_drive_value_bit;
            special_function_io_control <= next_special_function_io_control;
            system_ctrl <= next_system_ctrl;
            int_enable <= next_int_enable;
            int_flag <= next_int_flag;
            was_clamping <= deep_sleep;
            o_pad_out <= next_pad_out;
            o_pad_oe <= next_pad_oe;
            o_pad_pullup <= next_pad_pullup;
            o_timer_osc_out_enable <= timer_takeover; // R12
            o_crystal_out_enable <= crystal_takeover; // R14
        end
    end

endmodule

// *** logic/port_pin_consts.svh ***
// Constants for the port pin override block: register map, bit positions, timing.
`ifndef PORT_PIN_CONSTS_SVH
`define PORT_PIN_CONSTS_SVH

// Register word indices (byte address bits 5:2)
`define ADDR_DIRECTION 4'h0
`define ADDR_DRIVE 4'h1
`define ADDR_SAMPLE 4'h2
`define ADDR_SPECIAL_IO 4'h3
`define ADDR_SYSTEM_CTRL 4'h4
`define ADDR_INT_CTRL 4'h5
`define ADDR_INT_FLAG 4'h6
// Address decode width
`define ADDR_W 6
`define ADDR_WORD_LSB 2

// Special function control: global pull-up disable
`define SFIO_PULLUP_DISABLE_BIT 2
`define SFIO_RESET 8'h00
// System control bits
`define SYS_ASYNC_TIMER_BIT 0
`define SYS_INTRC_BIT 1
`define SYS_CRYSTAL_BIT 2
`define SYS_RESET 8'h00
// Pin seven of port B sits at index PIN_SEVEN + 4
`define PIN_SEVEN 3
`define PORT_RESET 8'h00

// Read answer latency in cycles after the request is seen
`define READ_WAIT_CYCLES 1

`endif

// *** logic/port_pin_pkg.sv ***
// Types shared by the port pin override logic.
package port_pin_pkg;

    // Sleep controller modes
    typedef enum logic [2:0]
    {
        sleep_active_type_v = 3'h0,
        sleep_idle_type_v = 3'h1,
        sleep_adc_type_v = 3'h2,
        sleep_power_down_type_v = 3'h3,
        sleep_power_save_type_v = 3'h4,
        sleep_standby_type_v = 3'h5
    } sleep_mode_type;

    // Bus slave state
    typedef enum logic [1:0]
    {
        bus_idle = 2'h0,
        bus_answer = 2'h1,
        bus_done = 2'h2
    } bus_state_type;

endpackage

// *** logic/pin_input_sync.sv ***
// Three-stage pad input synchroniser with agreement filter.
`include "port_pin_consts.svh"
module pin_input_sync
#(
    parameter int WIDTH = 8
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] stage_two;
    logic [WIDTH-1:0] stage_three;
    logic [WIDTH-1:0] held;
    logic [WIDTH-1:0] next_held;

    initial
    begin
        if (WIDTH < 1)
        begin
            $error("pin_input_sync: WIDTH must be positive");
        end
    end

    // A change counts only once the last two stages agree
    always_comb
    begin
        next_held = held;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (stage_two[i] == stage_three[i])
            begin
                next_held[i] = stage_three[i];
            end
        end
    end

    // Stage one is read only by stage two
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            stage_one <= '0;
            stage_two <= '0;
            stage_three <= '0;
            held <= '0;
        end
        else
        begin
            stage_one <= i_async;
            stage_two <= stage_one;
            stage_three <= stage_two;
            held <= next_held;
        end
    end

    assign o_sync = held;

endmodule

// *** test/port_pin_override_asserts.sv ***
// Port-level assertions for the port pin override block.
`include "port_pin_consts.svh"
module port_pin_override_asserts
#(
    parameter int PINS = 8
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [`ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [PINS-1:0] i_pullup_override_enable,
    input wire logic [PINS-1:0] i_pullup_override_value,
    input wire logic [PINS-1:0] i_direction_override_enable,
    input wire logic [PINS-1:0] i_direction_override_value,
    input wire logic [PINS-1:0] i_value_override_enable,
    input wire logic [PINS-1:0] i_value_override_value,
    input wire logic [PINS-1:0] i_input_enable_override_enable,
    input wire logic [2:0] i_sleep_mode,
    input wire logic [PINS-1:0] i_pad_in,
    input wire logic [PINS-1:0] o_pad_out,
    input wire logic [PINS-1:0] o_pad_oe,
    input wire logic [PINS-1:0] o_pad_pullup,
    input wire logic [PINS-1:0] o_alt_digital_input,
    input wire logic o_timer_osc_out_enable,
    input wire logic o_crystal_out_enable
);
    // ----
    // Checks
    // ----
    // Top pin doubles as a clock pin, so per-pin checks leave it out
    localparam logic [PINS-1:0] low_mask = {1'b0, {(PINS-1){1'b1}}};
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    a_pullup_override: assert property ($past(i_rst_n) |-> ((o_pad_pullup ^
        $past(i_pullup_override_value)) & $past(i_pullup_override_enable) & low_mask) == '0)
        else $error("pull-up ignores its override");
    a_direction_override: assert property ($past(i_rst_n) |-> ((o_pad_oe ^
        $past(i_direction_override_value)) & $past(i_direction_override_enable) & low_mask)
        == '0) else $error("driver enable ignores its override");
    a_value_override: assert property ($past(i_rst_n) |-> ((o_pad_out ^
        $past(i_value_override_value)) & $past(i_value_override_enable) & o_pad_oe
        & low_mask) == '0) else $error("pad level ignores its override");
    a_awake_input_passes: assert property (i_sleep_mode == 3'h0 |-> ((o_alt_digital_input
        ^ i_pad_in) & ~i_input_enable_override_enable & low_mask) == '0)
        else $error("awake input does not follow the pad");
    a_reset_pullup_off: assert property (disable iff (1'b0) !i_rst_n |-> o_pad_pullup == '0)
        else $error("pull-up on during reset");
    a_clock_pin_free: assert property ((o_crystal_out_enable || o_timer_osc_out_enable)
        |-> !o_pad_oe[PINS-1] && !o_pad_pullup[PINS-1])
        else $error("clock pin still driven by port");
    a_wait_one_cycle: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_request_answered: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |-> ##[1:3] !o_avs_waitrequest) else $error("request not answered");
    a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest
        && i_avs_address[5:2] > 4'h6 |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    c_read: cover property (i_avs_read && !o_avs_waitrequest);
    c_timer: cover property (o_timer_osc_out_enable);
    c_crystal: cover property (o_crystal_out_enable);
endmodule

bind port_pin_override_logic port_pin_override_asserts #(.PINS(PINS))
    i_port_pin_override_asserts (.*);

// *** test/pad_model.sv ***
// Behavioural model of the pads and of whatever drives them from outside.
module pad_model
(
    input wire logic i_core_clk,
    input wire logic [7:0] i_pad_out,
    input wire logic [7:0] i_pad_oe,
    input wire logic [7:0] i_pad_pullup,
    input wire logic [7:0] i_ext_drive,
    input wire logic [7:0] i_ext_value,
    output logic [7:0] o_level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] float_q = 8'h00;
    // Undriven lines without pull-up flip each cycle, so no stale level is read
    always_ff @(posedge i_core_clk)
        float_q <= ~o_level;
    // Own driver wins, then the outside driver, then pull-up, else floating
    always_comb
        o_level = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext_drive & i_ext_value)
            | (~i_pad_oe & ~i_ext_drive & (i_pad_pullup | float_q));
endmodule

// *** test/port_pin_override_logic_test.sv ***
// Self-checking bench for the port pin override block.
module port_pin_override_logic_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b1;
    logic [5:0] address = 6'h00;
    logic read = 1'b0, write = 1'b0, waitrequest, tosc_en, xtal_en;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [7:0] pu_en = 8'h00, pu_val = 8'h00, dir_en = 8'h00, dir_val = 8'h00;
    logic [7:0] out_en = 8'h00, out_val = 8'h00, in_en = 8'h00, in_val = 8'h00;
    logic [7:0] ext_drive = 8'h00, ext_value = 8'h00;
    logic [7:0] pad_in, pad_out, pad_oe, pad_pullup, alt_in;
    logic [2:0] sleep = 3'h0;
    int fail_count = 0, tests_run = 0;
    // ----
    // Clock and instances
    // ----
    always #2 i_core_clk = ~i_core_clk;
    port_pin_override_logic i_port_pin_override_logic (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .i_avs_address(address), .i_avs_read(read), .i_avs_write(write),
        .i_avs_writedata(writedata), .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest),
        .i_pullup_override_enable(pu_en), .i_pullup_override_value(pu_val),
        .i_direction_override_enable(dir_en), .i_direction_override_value(dir_val),
        .i_value_override_enable(out_en), .i_value_override_value(out_val),
        .i_input_enable_override_enable(in_en), .i_input_enable_override_value(in_val),
        .i_sleep_mode(sleep), .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
        .o_pad_pullup(pad_pullup), .o_alt_digital_input(alt_in),
        .o_timer_osc_out_enable(tosc_en), .o_crystal_out_enable(xtal_en));
    pad_model i_pad_model (.i_core_clk(i_core_clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe),
        .i_pad_pullup(pad_pullup), .i_ext_drive(ext_drive), .i_ext_value(ext_value),
        .o_level(pad_in));
    // Compare and count
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One transfer; waitrequest is sampled at the rising edge, request held until then
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_core_clk);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= !wr;
        do
        begin
            @(posedge i_core_clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0)
        begin
            fail_count++;
            $display("[FAIL] bus answer expected 0 seen 1");
            results();
        end
    endtask
    task automatic set3(input logic [7:0] d, input logic [7:0] v, input logic [7:0] p);
        bus(1'b1, 6'h00, d);
        bus(1'b1, 6'h04, v);
        bus(1'b1, 6'h0c, p);
        repeat (2) @(posedge i_core_clk);
    endtask
    // Reset at start and again at the end of the run with a pull-up on
    task automatic t_reset(input bit mid);
        if (mid)
        begin
            set3(8'h00, 8'hff, 8'h00);
            check("pull-up", 8'hff, pad_pullup);
        end
        i_rst_n <= 1'b0;
        @(negedge i_core_clk);
        check("pull-up in reset", 8'h00, pad_pullup);
        repeat (20) @(posedge i_core_clk);
        check("waitrequest in reset", 8'h01, {7'h0, waitrequest});
        i_rst_n <= 1'b1;
        for (int a = 0; a < 20; a += 4)
        begin
            bus(1'b0, a[5:0], 8'h00);
            check("register reset", 8'h00, q[7:0]);
        end
    endtask
    // Every direction, drive and global-disable combination
    task automatic t_pullup();
        for (int k = 0; k < 8; k++)
        begin
            set3({8{k[2]}}, {8{k[1]}}, {5'h0, k[0], 2'h0});
            check("pull-up", (k == 2) ? 8'hff : 8'h00, pad_pullup);
            check("output enable", {8{k[2]}}, pad_oe);
            check("output level", {8{k[2] & k[1]}}, pad_out & pad_oe);
            repeat (4) @(posedge i_core_clk);
            bus(1'b0, 6'h08, 8'h00);
            if (k[2] || k == 2)
                check("sample", {8{k[1]}}, q[7:0]);
        end
    endtask
    task automatic t_override();
        set3(8'h00, 8'hff, 8'h04);
        pu_en <= 8'hff;
        pu_val <= 8'ha5;
        dir_en <= 8'hff;
        dir_val <= 8'h3c;
        out_en <= 8'hff;
        out_val <= 8'h0f;
        repeat (2) @(posedge i_core_clk);
        check("pull-up override", 8'ha5, pad_pullup);
        check("direction override", 8'h3c, pad_oe);
        check("value override", 8'h0c, pad_out & pad_oe);
        out_en <= 8'h00;
        repeat (2) @(posedge i_core_clk);
        check("drive value", 8'h3c, pad_out & pad_oe);
        pu_en <= 8'h00;
        dir_en <= 8'h00;
    endtask
    // Every sleep mode, then the input-enable override
    task automatic t_input();
        set3(8'h00, 8'h00, 8'h00);
        ext_drive <= 8'hff;
        ext_value <= 8'hff;
        for (int m = 0; m < 6; m++)
        begin
            sleep <= m[2:0];
            repeat (2) @(posedge i_core_clk);
            check("alternate input", (m >= 3) ? 8'h00 : 8'hff, alt_in);
        end
        in_en <= 8'hff;
        in_val <= 8'h0f;
        repeat (2) @(posedge i_core_clk);
        check("input override", 8'h0f, alt_in);
        sleep <= 3'h0;
        in_val <= 8'h00;
        repeat (2) @(posedge i_core_clk);
        check("input override", 8'h00, alt_in);
        in_en <= 8'h00;
    endtask
    task automatic t_wake();
        bus(1'b1, 6'h18, 8'hff);
        bus(1'b1, 6'h14, 8'h01);
        sleep <= 3'h3;
        repeat (2) @(posedge i_core_clk);
        check("clamp bypass", 8'h01, alt_in);
        sleep <= 3'h0;
        repeat (4) @(posedge i_core_clk);
        bus(1'b0, 6'h18, 8'h00);
        check("wake flags", 8'hfe, q[7:0]);
        bus(1'b1, 6'h18, 8'hff);
        bus(1'b0, 6'h18, 8'h00);
        check("flags cleared", 8'h00, q[7:0]);
        bus(1'b1, 6'h14, 8'h00);
    endtask
    // All system control settings against the top pin
    task automatic t_pin7();
        set3(8'h80, 8'h80, 8'h00);
        ext_drive <= 8'h00;
        for (int s = 0; s < 8; s++)
        begin
            bus(1'b1, 6'h10, s[7:0]);
            repeat (2) @(posedge i_core_clk);
            check("crystal pin", {7'h0, s[2]}, {7'h0, xtal_en});
            check("timer pin", {7'h0, s == 3}, {7'h0, tosc_en});
            check("pin driver", {7'h0, !(s[2] || s == 3)}, {7'h0, pad_oe[7]});
            for (int a = 0; a < 12; a += 4)
            begin
                bus(1'b0, a[5:0], 8'h00);
                check("pin read", {!(s[2] || s == 3), 7'h0}, {q[7], 7'h0});
            end
        end
        bus(1'b1, 6'h10, 8'h00);
    endtask
    task automatic t_bus();
        set3(8'hff, 8'h00, 8'h00);
        bus(1'b1, 6'h1c, 8'h5a);
        bus(1'b1, 6'h08, 8'hff);
        bus(1'b0, 6'h1c, 8'h00);
        check("unmapped read", 8'h00, q[7:0]);
        bus(1'b0, 6'h08, 8'h00);
        check("sample read only", 8'h00, q[7:0]);
        bus(1'b0, 6'h00, 8'h00);
        check("direction kept", 8'hff, q[7:0]);
    endtask
    initial
    begin
        t_reset(1'b0);
        t_pullup();
        t_override();
        t_input();
        t_wake();
        t_pin7();
        t_bus();
        t_reset(1'b1);
        results();
    end
endmodule
